// ===== rtl/brcu_pkg.sv
// brcu_pkg: constants, opcodes and carrier types of the branch-control unit.
// Assumes 16-bit instruction words and a 16-bit program counter.
package brcu_pkg;

  localparam int          BRCU_W            = 16;

  // first-word opcode fields
  localparam int          BRCU_OP_HI        = 15;
  localparam int          BRCU_OP_LO        = 10;
  localparam logic [5:0]  BRCU_OP_COND      = 6'h38;
  localparam logic [5:0]  BRCU_OP_COND_DLY  = 6'h3C;
  localparam int          BRCU_LOOP_HI      = 15;
  localparam int          BRCU_LOOP_LO      = 8;
  localparam logic [7:0]  BRCU_OP_LOOP_DLY  = 8'h7F;
  localparam logic [7:0]  BRCU_OP_LOOP      = 8'h7B;
  localparam int          BRCU_IND_BIT      = 7;
  localparam int          BRCU_MOD_HI       = 6;
  localparam int          BRCU_MOD_LO       = 4;
  localparam logic [2:0]  BRCU_MOD_DEFAULT  = 3'h0;

  // condition fields of the conditional forms
  localparam int          BRCU_TP_HI        = 9;
  localparam int          BRCU_TP_LO        = 8;
  localparam int          BRCU_MASK_HI      = 7;
  localparam int          BRCU_MASK_LO      = 4;
  localparam int          BRCU_VAL_HI       = 3;
  localparam int          BRCU_VAL_LO       = 0;
  localparam int          BRCU_Z            = 3;
  localparam int          BRCU_L            = 2;
  localparam int          BRCU_V            = 1;
  localparam int          BRCU_C            = 0;
  localparam logic [1:0]  BRCU_TP_PIN_LOW   = 2'h0;
  localparam logic [1:0]  BRCU_TP_TC_SET    = 2'h1;
  localparam logic [1:0]  BRCU_TP_TC_CLEAR  = 2'h2;
  localparam logic [1:0]  BRCU_TP_NONE      = 2'h3;

  // sequencing
  localparam logic [15:0] BRCU_PC_STEP      = 16'h0002;
  localparam logic [15:0] BRCU_AUX_DEC      = 16'h0001;
  localparam logic [15:0] BRCU_PC_RESET     = 16'h0000;
  localparam logic [1:0]  BRCU_SLOT_WORDS   = 2'h2;
  localparam logic [1:0]  BRCU_SQUASH_WORDS = 2'h2;

  typedef struct packed {
    logic acc_zero;
    logic acc_neg;
    logic carry;
    logic overflow;
    logic test_control_flag;
  } brcu_flags_type;

  typedef enum logic [3:0] {
    BRCU_IDLE   = 4'h1,
    BRCU_TARGET = 4'h2,
    BRCU_SLOT   = 4'h4,
    BRCU_SQUASH = 4'h8
  } brcu_state_type;

endpackage : brcu_pkg

// ===== rtl/brcu_branch_unit.sv
// brcu_branch_unit: decodes the loop and conditional branch forms from the
// in-order instruction word stream, tracks the program counter and redirects it.
// Assumes program memory presents one word per cycle with instr_valid, and
// the datapath supplies the selected auxiliary register and status flags.
//
// Contract
// - loop branch: aux nonzero jumps, else plus two
// - loop branch decrements aux unless other modification
// - delayed loop branch runs two slot words first; plain loop squashes two
// - zero test before decrement: N-1 gives N
// - these branches refuse single-instruction repeat
// - plain branch squashes two words; 4/2 cycles
// - conditional branch: met jumps, else plus two
// - conditions: acc, carry, overflow, test flag, pin
// - several conditions must all hold together
// - test flag and pin never tested together
// - delayed conditional runs two slot words first
// - delayed conditions sampled before slot words
// - after slots jump if met, else continue
// - plain loop taken 4 cycles, not taken 2
`timescale 1ns/10ps

module brcu_branch_unit
  import brcu_pkg::*;
#(
  parameter int W = BRCU_W
) (
  input  wire logic           sys_clk,
  input  wire logic           reset,
  input  wire logic           instr_valid,
  input  wire logic [W-1:0]   instr_word,
  input  wire brcu_flags_type status_flags,
  input  wire logic [W-1:0]   auxiliary_pointer_reg,
  input  wire logic           repeat_active,
  input  wire logic           branch_input_pin,
  output logic [W-1:0]        pc,
  output logic                pc_redirect,
  output logic                word_discard,
  output logic                delay_slot,
  output logic                aux_write,
  output logic [W-1:0]        aux_write_data,
  output logic                repeat_refused,
  output logic                branch_busy
);

  // pin synchroniser
  logic bio_meta_r;
  logic bio_sync_r;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bio_meta_r <= 1'b1;
      bio_sync_r <= 1'b1;
    end else begin
      bio_meta_r <= branch_input_pin;
      bio_sync_r <= bio_meta_r;
    end
  end

  // condition evaluation; all selected tests are anded
  function automatic logic cond_met(input logic [W-1:0]   w,
                                    input brcu_flags_type f,
                                    input logic           pin);
    logic [3:0] m;
    logic [3:0] v;
    logic [1:0] tp;
    logic       ok;
    m  = w[BRCU_MASK_HI:BRCU_MASK_LO];
    v  = w[BRCU_VAL_HI:BRCU_VAL_LO];
    tp = w[BRCU_TP_HI:BRCU_TP_LO];
    ok = 1'b1;
    if (m[BRCU_Z] && m[BRCU_L]) begin
      // zl pairs: 11 le, 10 ge, 01 lt, 00 gt
      case ({v[BRCU_Z], v[BRCU_L]})
        2'h3:    ok = ok & (f.acc_zero | f.acc_neg);
        2'h2:    ok = ok & ~f.acc_neg;
        2'h1:    ok = ok & f.acc_neg;
        default: ok = ok & ~f.acc_zero & ~f.acc_neg;
      endcase
    end else if (m[BRCU_Z]) begin
      ok = ok & (f.acc_zero == v[BRCU_Z]);
    end else if (m[BRCU_L]) begin
      ok = ok & (f.acc_neg == v[BRCU_L]);
    end
    if (m[BRCU_V]) begin
      ok = ok & (f.overflow == v[BRCU_V]);
    end
    if (m[BRCU_C]) begin
      ok = ok & (f.carry == v[BRCU_C]);
    end
    // one shared field selects pin or flag, never both
    case (tp)
      BRCU_TP_PIN_LOW:  ok = ok & ~pin;
      BRCU_TP_TC_SET:   ok = ok & f.test_control_flag;
      BRCU_TP_TC_CLEAR: ok = ok & ~f.test_control_flag;
      default:          ok = ok;
    endcase
    return ok;
  endfunction : cond_met

  // decode of the first word
  logic is_cond;
  logic is_cond_dly;
  logic is_loop_dly;
  logic is_loop;
  logic is_branch;
  logic loop_default_mod;

  always_comb begin
    is_cond     = instr_word[BRCU_OP_HI:BRCU_OP_LO] == BRCU_OP_COND;
    is_cond_dly = instr_word[BRCU_OP_HI:BRCU_OP_LO] == BRCU_OP_COND_DLY;
    is_loop_dly = instr_word[BRCU_LOOP_HI:BRCU_LOOP_LO] == BRCU_OP_LOOP_DLY;
    // plain loop form reuses the squash path of the plain branch
    is_loop     = instr_word[BRCU_LOOP_HI:BRCU_LOOP_LO] == BRCU_OP_LOOP;
    is_branch   = is_cond | is_cond_dly | is_loop_dly | is_loop;
    loop_default_mod = ~instr_word[BRCU_IND_BIT]
                     | (instr_word[BRCU_MOD_HI:BRCU_MOD_LO] == BRCU_MOD_DEFAULT);
  end

  // sequencer state
  brcu_state_type state_r;
  brcu_state_type state_nxt;
  logic [W-1:0]   pc_r;
  logic [W-1:0]   pc_nxt;
  logic [W-1:0]   br_addr_r;
  logic [W-1:0]   br_addr_nxt;
  logic [W-1:0]   target_r;
  logic [W-1:0]   target_nxt;
  logic           taken_r;
  logic           taken_nxt;
  logic           delayed_r;
  logic           delayed_nxt;
  logic [1:0]     count_r;
  logic [1:0]     count_nxt;
  logic           redirect_r;
  logic           redirect_nxt;
  logic           discard_r;
  logic           discard_nxt;
  logic           slot_r;
  logic           slot_nxt;
  logic           aux_wr_r;
  logic           aux_wr_nxt;
  logic [W-1:0]   aux_data_r;
  logic [W-1:0]   aux_data_nxt;
  logic           refused_r;
  logic           refused_nxt;

  always_comb begin
    state_nxt    = state_r;
    pc_nxt       = pc_r;
    br_addr_nxt  = br_addr_r;
    target_nxt   = target_r;
    taken_nxt    = taken_r;
    delayed_nxt  = delayed_r;
    count_nxt    = count_r;
    redirect_nxt = 1'b0;
    discard_nxt  = discard_r;
    slot_nxt     = slot_r;
    aux_wr_nxt   = 1'b0;
    aux_data_nxt = aux_data_r;
    refused_nxt  = 1'b0;
    case (state_r)
      BRCU_IDLE: begin
        if (instr_valid) begin
          pc_nxt = pc_r + W'(1);
          if (is_branch) begin
            state_nxt   = BRCU_TARGET;
            br_addr_nxt = pc_r;
            delayed_nxt = is_cond_dly | is_loop_dly;
            // repeat is ignored: the branch runs once
            refused_nxt = repeat_active;
            if (is_loop_dly | is_loop) begin
              // zero test uses the value before the decrement
              taken_nxt = auxiliary_pointer_reg != '0;
              if (loop_default_mod) begin
                aux_wr_nxt   = 1'b1;
                aux_data_nxt = auxiliary_pointer_reg - BRCU_AUX_DEC;
              end
            end else begin
              // flags caught now, so slot words cannot change the outcome
              taken_nxt = cond_met(instr_word, status_flags, bio_sync_r);
            end
          end
        end
      end
      BRCU_TARGET: begin
        if (instr_valid) begin
          target_nxt = instr_word;
          if (delayed_r) begin
            pc_nxt    = pc_r + W'(1);
            state_nxt = BRCU_SLOT;
            count_nxt = BRCU_SLOT_WORDS;
            slot_nxt  = 1'b1;
          end else if (taken_r) begin
            pc_nxt       = instr_word;
            redirect_nxt = 1'b1;
            state_nxt    = BRCU_SQUASH;
            count_nxt    = BRCU_SQUASH_WORDS;
            discard_nxt  = 1'b1;
          end else begin
            pc_nxt    = br_addr_r + BRCU_PC_STEP;
            state_nxt = BRCU_IDLE;
          end
        end
      end
      BRCU_SLOT: begin
        if (instr_valid) begin
          pc_nxt    = pc_r + W'(1);
          count_nxt = count_r - 2'h1;
          if (count_r == 2'h1) begin
            slot_nxt  = 1'b0;
            state_nxt = BRCU_IDLE;
            if (taken_r) begin
              pc_nxt       = target_r;
              redirect_nxt = 1'b1;
            end
          end
        end
      end
      BRCU_SQUASH: begin
        // speculative words after a taken plain branch are dropped
        if (instr_valid) begin
          count_nxt = count_r - 2'h1;
          if (count_r == 2'h1) begin
            discard_nxt = 1'b0;
            state_nxt   = BRCU_IDLE;
          end
        end
      end
      default: begin
        state_nxt   = BRCU_IDLE;
        discard_nxt = 1'b0;
        slot_nxt    = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r    <= BRCU_IDLE;
      pc_r       <= BRCU_PC_RESET;
      br_addr_r  <= BRCU_PC_RESET;
      target_r   <= BRCU_PC_RESET;
      taken_r    <= 1'b0;
      delayed_r  <= 1'b0;
      count_r    <= 2'h0;
      redirect_r <= 1'b0;
      discard_r  <= 1'b0;
      slot_r     <= 1'b0;
      aux_wr_r   <= 1'b0;
      aux_data_r <= '0;
      refused_r  <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      pc_r       <= pc_nxt;
      br_addr_r  <= br_addr_nxt;
      target_r   <= target_nxt;
      taken_r    <= taken_nxt;
      delayed_r  <= delayed_nxt;
      count_r    <= count_nxt;
      redirect_r <= redirect_nxt;
      discard_r  <= discard_nxt;
      slot_r     <= slot_nxt;
      aux_wr_r   <= aux_wr_nxt;
      aux_data_r <= aux_data_nxt;
      refused_r  <= refused_nxt;
    end
  end

  // no flag outputs exist: status bits stay untouched
  assign pc             = pc_r;
  assign pc_redirect    = redirect_r;
  assign word_discard   = discard_r;
  assign delay_slot     = slot_r;
  assign aux_write      = aux_wr_r;
  assign aux_write_data = aux_data_r;
  assign repeat_refused = refused_r;
  // only delayed forms ever set slot_r, so no gate is needed
  assign branch_busy    = slot_r;

endmodule : brcu_branch_unit

// ===== verification/brcu_prog_mem.sv
// brcu_prog_mem: program memory model feeding words in order from a queue.
// Assumes the bench pushes words into q; slow inserts a stall every other cycle.
`timescale 1ns/10ps

module brcu_prog_mem (
  input  wire logic  sys_clk,
  input  wire logic  reset,
  input  wire logic  slow,
  output logic       instr_valid,
  output logic [15:0] instr_word
);
  logic [15:0] q[$];
  logic        skip;

  initial begin
    instr_valid = 1'b0;
    instr_word  = 16'h0000;
    skip        = 1'b0;
  end

  always @(posedge sys_clk) begin
    #1;
    skip = slow && !skip;
    if (!reset && q.size() > 0 && !skip) begin
      instr_valid = 1'b1;
      instr_word  = q.pop_front();
    end else begin
      instr_valid = 1'b0;
      // idle bus must not look like the last word
      instr_word  = ~instr_word;
    end
  end
endmodule : brcu_prog_mem

// ===== verification/brcu_monitor.sv
// brcu_monitor: port-level checks of the branch-control unit.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps

module brcu_monitor #(
  parameter int W = 16
) (
  input wire logic         sys_clk,
  input wire logic         reset,
  input wire logic         instr_valid,
  input wire logic [W-1:0] instr_word,
  input wire logic [W-1:0] auxiliary_pointer_reg,
  input wire logic         repeat_active,
  input wire logic [W-1:0] pc,
  input wire logic         pc_redirect,
  input wire logic         word_discard,
  input wire logic         delay_slot,
  input wire logic         aux_write,
  input wire logic [W-1:0] aux_write_data,
  input wire logic         repeat_refused,
  input wire logic         branch_busy
);
  logic [1:0] disc_n_r;
  logic [1:0] disc_n_nxt;
  logic [1:0] slot_n_r;
  logic [1:0] slot_n_nxt;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  // counts words accepted while discarding or in delay slots
  always_comb begin
    disc_n_nxt = word_discard ? disc_n_r + {1'b0, instr_valid} : 2'h0;
    slot_n_nxt = delay_slot ? slot_n_r + {1'b0, instr_valid} : 2'h0;
  end

  always_ff @(posedge sys_clk) begin
    disc_n_r <= reset ? 2'h0 : disc_n_nxt;
    slot_n_r <= reset ? 2'h0 : slot_n_nxt;
  end

  chk_redir_pulse: assert property (
    pc_redirect |=> !pc_redirect) else $error("redirect held too long");
  chk_aux_pulse: assert property (
    aux_write |=> !aux_write) else $error("aux write held too long");
  chk_aux_data: assert property (
    aux_write |-> aux_write_data == $past(auxiliary_pointer_reg) - 1'b1) else $error("aux data wrong");
  chk_refuse_cause: assert property (
    repeat_refused |-> $past(repeat_active) && $past(instr_valid)) else $error("refusal without repeat");
  chk_discard_two: assert property (
    $fell(word_discard) |-> disc_n_r == 2'h2) else $error("discard count wrong");
  chk_slot_two: assert property (
    $fell(delay_slot) |-> slot_n_r == 2'h2) else $error("slot count wrong");
  chk_slot_hold: assert property (
    delay_slot |-> branch_busy && !pc_redirect) else $error("redirect inside slots");
  chk_redir_cause: assert property (
    pc_redirect |-> $rose(word_discard) || $fell(delay_slot)) else $error("redirect at wrong time");
  chk_redir_target: assert property (
    $rose(word_discard) |-> pc == $past(instr_word)) else $error("target not loaded");
endmodule : brcu_monitor

bind brcu_branch_unit brcu_monitor #(.W(W)) u_mon (
  .sys_clk(sys_clk), .reset(reset), .instr_valid(instr_valid), .instr_word(instr_word),
  .auxiliary_pointer_reg(auxiliary_pointer_reg), .repeat_active(repeat_active), .pc(pc),
  .pc_redirect(pc_redirect), .word_discard(word_discard), .delay_slot(delay_slot),
  .aux_write(aux_write), .aux_write_data(aux_write_data), .repeat_refused(repeat_refused),
  .branch_busy(branch_busy));

// ===== verification/brcu_bench.sv
// brcu_bench: self-checking bench of the branch-control unit.
// Assumes brcu_prog_mem feeds the word stream; flags and aux come from here.
`timescale 1ns/10ps

module brcu_bench
  import brcu_pkg::*;
;
  logic           sys_clk = 1'b0;
  logic           reset   = 1'b1;
  logic           slow    = 1'b0;
  logic           rpt     = 1'b0;
  logic           pin     = 1'b1;
  logic [15:0]    aux     = 16'h0000;
  brcu_flags_type fl      = '0;
  logic           iv, pr, wd, ds, aw, rr;
  logic [15:0]    iw, pc, awd, w;
  logic [15:0]    ppc        = 16'h0000;
  logic [17:0]    exp_q[$];
  logic [17:0]    e;
  int             n_mismatch = 0;
  int             compares   = 0;
  integer         seed       = 40424;
  int             k;

  always #5 sys_clk = ~sys_clk;

  brcu_prog_mem mem (.sys_clk(sys_clk), .reset(reset), .slow(slow), .instr_valid(iv), .instr_word(iw));
  brcu_branch_unit dut (
    .sys_clk(sys_clk), .reset(reset), .instr_valid(iv), .instr_word(iw), .status_flags(fl),
    .auxiliary_pointer_reg(aux), .repeat_active(rpt), .branch_input_pin(pin), .pc(pc),
    .pc_redirect(pr), .word_discard(wd), .delay_slot(ds), .aux_write(aw),
    .aux_write_data(awd), .repeat_refused(rr), .branch_busy());

  task automatic chk(input logic [17:0] x, input logic [17:0] g);
    compares++;
    if (g !== x) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk

  task automatic results();
    $display("mismatches %0d of %0d compares", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results

  function automatic logic met(logic [15:0] c);
    logic ok;
    ok = (c[9:8] == 2'h0) ? !pin : (c[9:8] == 2'h1) ? fl.test_control_flag :
         (c[9:8] == 2'h2) ? !fl.test_control_flag : 1'b1;
    if (c[7] && c[6])
      case (c[3:2])
        2'h3: ok &= fl.acc_zero | fl.acc_neg;
        2'h2: ok &= !fl.acc_neg;
        2'h1: ok &= fl.acc_neg;
        default: ok &= !fl.acc_zero && !fl.acc_neg;
      endcase
    else if (c[7]) ok &= fl.acc_zero == c[3];
    else if (c[6]) ok &= fl.acc_neg == c[2];
    if (c[5]) ok &= fl.overflow == c[1];
    if (c[4]) ok &= fl.carry == c[0];
    return ok;
  endfunction : met

  task automatic rnd_flags();
    fl = brcu_flags_type'(5'($random(seed)));
    // a zero accumulator cannot be negative
    if (fl.acc_zero) fl.acc_neg = 1'b0;
  endtask : rnd_flags

  // one branch: opcode, target, two following words
  task automatic br(input logic [15:0] op, input logic [15:0] tgt, input logic tk, input logic awr);
    repeat (3) @(posedge sys_clk);
    #1;
    if (rpt) exp_q.push_back(18'h20000);
    if (awr) exp_q.push_back({2'h1, aux - 16'h0001});
    if (tk) exp_q.push_back({2'h0, tgt});
    // after op, target and two more words: target if taken, else four words on
    ppc = tk ? tgt : ppc + 16'h0004;
    mem.q.push_back(op);
    mem.q.push_back(tgt);
    mem.q.push_back({2'h0, 14'($random(seed))});
    mem.q.push_back({2'h0, 14'($random(seed))});
    for (int i = 0; i < 8 && !ds && !wd; i++) @(posedge sys_clk);
    #1;
    rnd_flags();
    while (mem.q.size() != 0) @(posedge sys_clk);
    repeat (3) @(posedge sys_clk);
    #1;
    chk({2'h0, ppc}, {2'h0, pc});
  endtask : br

  always @(posedge sys_clk) begin
    if (!reset && (pr || aw || rr)) begin
      e = (exp_q.size() != 0) ? exp_q.pop_front() : 18'h3FFFF;
      chk(e, rr ? 18'h20000 : aw ? {2'h1, awd} : {2'h0, pc});
    end
  end

  initial begin
    repeat (6000) @(posedge sys_clk);
    n_mismatch++;
    results();
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    aux = 16'h0002;
    for (k = 0; k < 3; k++) begin
      br({BRCU_OP_LOOP_DLY, 8'h00}, 16'h0100, aux != 16'h0000, 1'b1);
      aux = aux - 16'h0001;
    end
    br({BRCU_OP_LOOP_DLY, 8'h90}, 16'h0200, aux != 16'h0000, 1'b0);
    br({BRCU_OP_LOOP, 8'h00}, 16'h0400, 1'b1, 1'b1);
    aux = 16'h0000;
    br({BRCU_OP_LOOP, 8'h00}, 16'h0500, 1'b0, 1'b1);
    rpt = 1'b1;
    br({BRCU_OP_COND, 10'h300}, 16'h0300, 1'b1, 1'b0);
    rpt = 1'b0;
    for (k = 0; k < 60; k++) begin
      slow = k[3];
      rnd_flags();
      pin = 1'($random(seed));
      // one field selects pin or test flag, never both
      w = {k[0] ? BRCU_OP_COND_DLY : BRCU_OP_COND, 10'($random(seed))};
      br(w, 16'($random(seed)), met(w), 1'b0);
    end
    repeat (5) @(posedge sys_clk);
    chk(18'h0, 18'(exp_q.size()));
    results();
  end
endmodule : brcu_bench
